// file: verilog/spbr_pkg.sv
package spbr_pkg;
    // Register offsets on the plain register port
    localparam logic [1:0] SPBR_OFF_OPTION = 2'h0;
    localparam logic [1:0] SPBR_OFF_RATE = 2'h1;
    localparam logic [1:0] SPBR_OFF_SIDEBAND = 2'h2;
    localparam int SPBR_ADDR_W = 2;

    // Option control fields
    localparam int SPBR_OPT_MODF_EN_BIT = 4;
    localparam int SPBR_OPT_SW_OE_BIT = 3;
    localparam int SPBR_OPT_WAIT_STOP_BIT = 1;
    localparam int SPBR_OPT_SW_SEL_BIT = 0;
    localparam logic [7:0] SPBR_OPT_WR_MASK = 8'h1b;
    localparam logic [7:0] SPBR_OPT_RESET = 8'h00;

    // Bit-rate fields
    localparam int SPBR_PRE_LSB = 4;
    localparam int SPBR_DIV_LSB = 0;
    localparam logic [7:0] SPBR_RATE_WR_MASK = 8'h77;
    localparam logic [7:0] SPBR_RATE_RESET = 8'h00;

    typedef struct packed {
        logic mode_fault_enable;
        logic single_wire_output_enable;
        logic wait_mode_clock_stop;
        logic single_wire_select;
    } spbr_opt_t;

    typedef struct packed {
        logic [2:0] rate_prescale_field;
        logic [2:0] rate_divide_field;
    } spbr_rate_t;

    // Pin steering for one pin: drive value and enable
    typedef struct packed {
        logic spi_owned;
        logic out;
        logic oe_n;
    } spbr_pin_t;
endpackage

// file: verilog/spbr_rate_gen.sv
module spbr_rate_gen
    import spbr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire spbr_pkg::spbr_rate_t rate,
    output logic bit_tick,
    output logic bit_clk
);
    logic [2:0] pre_cnt_r, pre_cnt_nxt;
    logic [7:0] div_cnt_r, div_cnt_nxt;
    logic bit_clk_r, bit_clk_nxt;
    logic bit_tick_r, bit_tick_nxt;
    logic pre_tick;
    logic [7:0] half_last;

    always_comb
    begin
        // Half period of the divider, minus one, in prescaler ticks
        half_last = 8'((9'h1 << rate.rate_divide_field) - 9'h1);
        pre_tick = run && (pre_cnt_r >= rate.rate_prescale_field);
        pre_cnt_nxt = pre_cnt_r;
        div_cnt_nxt = div_cnt_r;
        bit_clk_nxt = bit_clk_r;
        bit_tick_nxt = 1'b0;
        if (!run)
        begin
            pre_cnt_nxt = 3'h0;
            div_cnt_nxt = 8'h00;
            bit_clk_nxt = 1'b0;
        end
        else if (pre_tick)
        begin
            pre_cnt_nxt = 3'h0;
            // Second stage counts only prescaler ticks
            if (div_cnt_r >= half_last)
            begin
                div_cnt_nxt = 8'h00;
                bit_clk_nxt = ~bit_clk_r;
                bit_tick_nxt = bit_clk_r;
            end
            else
            begin
                div_cnt_nxt = div_cnt_r + 8'h01;
            end
        end
        else
        begin
            pre_cnt_nxt = pre_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pre_cnt_r <= 3'h0;
            div_cnt_r <= 8'h00;
            bit_clk_r <= 1'b0;
            bit_tick_r <= 1'b0;
        end
        else
        begin
            pre_cnt_r <= pre_cnt_nxt;
            div_cnt_r <= div_cnt_nxt;
            bit_clk_r <= bit_clk_nxt;
            bit_tick_r <= bit_tick_nxt;
        end
    end

    assign bit_clk = bit_clk_r;
    assign bit_tick = bit_tick_r;
endmodule

// file: verilog/spbr_pin_ctrl.sv
// Operation
// - Option register bits 7, 6, 5 and 2 read as zero.
// - Slave mode ignores mode-fault enable; select pin is always slave input.
// - Master with mode fault off releases select pin to port logic.
// - Master with mode fault on uses select pin for fault or output.
// - Single-wire: output-enable bit 1 drives shared pin, 0 makes it input.
// - Separate-pin mode ignores the single-wire output-enable bit.
// - Wait-stop bit 1 halts serial clocks in wait; 0 keeps them.
// - Single-wire slave carries all data on the MISO pin.
// - Single-wire master carries all data on the MOSI pin.
// - Separate-pin mode uses distinct input and output data pins.
// - Bit-rate register is readable and writable at any time.
// - Prescale field divides bus clock by code plus one.
// - Prescaler output feeds the rate divider in series.
// - Rate field divides by two to the code plus one; master bit clock.
// - Select output enable 0 gives fault input, 1 gives driven select.
// - Single-wire master releases the MISO pin to port logic.
module spbr_pin_ctrl
    import spbr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [spbr_pkg::SPBR_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic master_select,
    input wire logic slave_select_output_enable,
    input wire logic spi_enable,
    input wire logic cpu_wait,
    input wire logic shift_active,
    input wire logic shift_out,
    input wire logic shift_drive,
    input wire logic ss_assert,
    output logic shift_in,
    output logic slave_select_in,
    output logic mode_fault_in,
    output logic serial_clk_run,
    output logic bit_tick,
    output logic bit_clk,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_n,
    output logic mosi_spi_owned,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_n,
    output logic miso_spi_owned,
    input wire logic ss_pin_in,
    output logic ss_out,
    output logic ss_oe_n,
    output logic ss_spi_owned
);
    logic [7:0] opt_r, opt_nxt;
    logic [7:0] rate_r, rate_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [2:0] mosi_s1_r, mosi_s2_r;
    spbr_opt_t opt;
    spbr_rate_t rate;
    spbr_pin_t mosi_p, miso_p, ss_p;
    logic mosi_q, miso_q, ss_q;
    logic single_wire, sw_drive;

    function automatic logic [7:0] spbr_rd_mux(
        input logic [SPBR_ADDR_W-1:0] a,
        input logic [7:0] o,
        input logic [7:0] r,
        input logic [7:0] s
    );
        unique case (a)
            SPBR_OFF_OPTION: spbr_rd_mux = o & SPBR_OPT_WR_MASK;
            SPBR_OFF_RATE: spbr_rd_mux = r & SPBR_RATE_WR_MASK;
            SPBR_OFF_SIDEBAND: spbr_rd_mux = s;
            default: spbr_rd_mux = 8'h00;
        endcase
    endfunction

    // Field views of the stored registers
    always_comb
    begin
        opt.mode_fault_enable = opt_r[SPBR_OPT_MODF_EN_BIT];
        opt.single_wire_output_enable = opt_r[SPBR_OPT_SW_OE_BIT];
        opt.wait_mode_clock_stop = opt_r[SPBR_OPT_WAIT_STOP_BIT];
        opt.single_wire_select = opt_r[SPBR_OPT_SW_SEL_BIT];
        rate.rate_prescale_field = rate_r[SPBR_PRE_LSB +: 3];
        rate.rate_divide_field = rate_r[SPBR_DIV_LSB +: 3];
    end

    // Register file; rate writes are never blocked by a transfer
    always_comb
    begin
        opt_nxt = opt_r;
        rate_nxt = rate_r;
        if (reg_wr && reg_addr == SPBR_OFF_OPTION)
        begin
            opt_nxt = reg_wdata & SPBR_OPT_WR_MASK;
        end
        if (reg_wr && reg_addr == SPBR_OFF_RATE)
        begin
            rate_nxt = reg_wdata & SPBR_RATE_WR_MASK;
        end
        rdata_nxt = 8'h00;
        if (reg_rd)
        begin
            rdata_nxt = spbr_rd_mux(reg_addr, opt_r, rate_r,
                {5'h00, serial_clk_run, ss_q, shift_active});
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            opt_r <= SPBR_OPT_RESET;
            rate_r <= SPBR_RATE_RESET;
            rdata_r <= 8'h00;
        end
        else
        begin
            opt_r <= opt_nxt;
            rate_r <= rate_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // Pin inputs come from outside; two flops before use
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mosi_s1_r <= 3'h7;
            mosi_s2_r <= 3'h7;
        end
        else
        begin
            mosi_s1_r <= {mosi_in, miso_in, ss_pin_in};
            mosi_s2_r <= mosi_s1_r;
        end
    end

    assign mosi_q = mosi_s2_r[2];
    assign miso_q = mosi_s2_r[1];
    assign ss_q = mosi_s2_r[0];

    // Wait stop gates the serial clocks only while the core waits
    assign serial_clk_run = spi_enable
        && !(cpu_wait && opt.wait_mode_clock_stop);

    spbr_rate_gen u_rate_gen
    (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .run(serial_clk_run && master_select),
        .rate(rate),
        .bit_tick(bit_tick),
        .bit_clk(bit_clk)
    );

    // Data pin steering
    always_comb
    begin
        single_wire = opt.single_wire_select;
        // Output enable bit only matters in single-wire mode
        sw_drive = single_wire && opt.single_wire_output_enable;
        mosi_p = '{spi_owned: 1'b0, out: 1'b0, oe_n: 1'b1};
        miso_p = '{spi_owned: 1'b0, out: 1'b0, oe_n: 1'b1};
        shift_in = 1'b0;
        if (spi_enable)
        begin
            if (!single_wire)
            begin
                // Separate input and output pins
                mosi_p.spi_owned = 1'b1;
                miso_p.spi_owned = 1'b1;
                if (master_select)
                begin
                    mosi_p.out = shift_out;
                    mosi_p.oe_n = 1'b0;
                    shift_in = miso_q;
                end
                else
                begin
                    miso_p.out = shift_out;
                    miso_p.oe_n = !shift_drive;
                    shift_in = mosi_q;
                end
            end
            else if (master_select)
            begin
                mosi_p.spi_owned = 1'b1;
                mosi_p.out = shift_out;
                mosi_p.oe_n = !sw_drive;
                shift_in = mosi_q;
                // MISO left to port logic
                miso_p.spi_owned = 1'b0;
            end
            else
            begin
                miso_p.spi_owned = 1'b1;
                miso_p.out = shift_out;
                miso_p.oe_n = !(sw_drive && shift_drive);
                shift_in = miso_q;
            end
        end
    end

    // Slave-select pin steering
    always_comb
    begin
        ss_p = '{spi_owned: 1'b0, out: 1'b1, oe_n: 1'b1};
        slave_select_in = 1'b1;
        mode_fault_in = 1'b1;
        if (spi_enable)
        begin
            if (!master_select)
            begin
                // Mode fault enable has no effect here
                ss_p.spi_owned = 1'b1;
                slave_select_in = ss_q;
            end
            else if (opt.mode_fault_enable)
            begin
                ss_p.spi_owned = 1'b1;
                if (slave_select_output_enable)
                begin
                    ss_p.out = !ss_assert;
                    ss_p.oe_n = 1'b0;
                end
                else
                begin
                    mode_fault_in = ss_q;
                end
            end
            else
            begin
                ss_p.spi_owned = 1'b0;
            end
        end
    end

    assign mosi_out = mosi_p.out;
    assign mosi_oe_n = mosi_p.oe_n;
    assign mosi_spi_owned = mosi_p.spi_owned;
    assign miso_out = miso_p.out;
    assign miso_oe_n = miso_p.oe_n;
    assign miso_spi_owned = miso_p.spi_owned;
    assign ss_out = ss_p.out;
    assign ss_oe_n = ss_p.oe_n;
    assign ss_spi_owned = ss_p.spi_owned;
endmodule

// file: tb/spbr_pin_ctrl_assertions.sv
module spbr_pin_ctrl_chk
    import spbr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [spbr_pkg::SPBR_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic master_select,
    input wire logic slave_select_output_enable,
    input wire logic spi_enable,
    input wire logic cpu_wait,
    input wire logic shift_out,
    input wire logic shift_drive,
    input wire logic ss_assert,
    input wire logic serial_clk_run,
    input wire logic bit_clk,
    input wire logic bit_tick,
    input wire logic shift_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    input wire logic mosi_out,
    input wire logic mosi_oe_n,
    input wire logic miso_oe_n,
    input wire logic miso_spi_owned,
    input wire logic ss_out,
    input wire logic ss_oe_n,
    input wire logic ss_spi_owned
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] opt_r, opt_nxt, rate_r, rate_nxt;
    logic [10:0] cnt_r, cnt_nxt;
    logic ok_r, ok_nxt, bq_r, rq_r;
    wire logic m = master_select & spi_enable;
    wire logic s = ~master_select & spi_enable;
    wire logic sso = m & opt_r[4] & slave_select_output_enable;
    wire logic flt = m & opt_r[4] & ~slave_select_output_enable;
    wire logic run = serial_clk_run & master_select;
    wire logic tog = bit_clk != bq_r;
    wire logic [10:0] half = (11'(rate_r[6:4]) + 11'h1) << rate_r[2:0];
    always_comb
    begin
        opt_nxt = opt_r;
        rate_nxt = rate_r;
        if (reg_wr && reg_addr == SPBR_OFF_OPTION)
            opt_nxt = reg_wdata & SPBR_OPT_WR_MASK;
        if (reg_wr && reg_addr == SPBR_OFF_RATE)
            rate_nxt = reg_wdata & SPBR_RATE_WR_MASK;
        // Start-up interval is partial, so only later ones are judged
        ok_nxt = tog ? rq_r : ok_r;
        cnt_nxt = tog ? 11'h1 : cnt_r + 11'h1;
        if (!run || reg_wr)
        begin
            ok_nxt = 1'b0;
            cnt_nxt = '0;
        end
    end
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            {opt_r, rate_r, cnt_r, ok_r, bq_r, rq_r} <= '0;
        else
            {opt_r, rate_r, cnt_r, ok_r, bq_r, rq_r} <=
                {opt_nxt, rate_nxt, cnt_nxt, ok_nxt, bit_clk, run};
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    opt_read_a: assert property (reg_rd && reg_addr == SPBR_OFF_OPTION
        |=> reg_rdata == $past(opt_r)) else $error("option readback");
    rate_read_a: assert property (reg_rd && reg_addr == SPBR_OFF_RATE
        |=> reg_rdata == $past(rate_r)) else $error("rate readback");
    ss_slave_a: assert property (s |-> ss_spi_owned && ss_oe_n)
        else $error("slave select pin");
    ss_free_a: assert property (m && !opt_r[4] |-> !ss_spi_owned)
        else $error("select pin kept");
    ss_drive_a: assert property (sso |-> ss_spi_owned && !ss_oe_n
        && ss_out == !ss_assert) else $error("select output");
    fault_in_a: assert property (flt |-> ss_spi_owned && ss_oe_n)
        else $error("fault input pin");
    sw_master_a: assert property (m && opt_r[0] |-> !miso_spi_owned
        && mosi_oe_n == !opt_r[3]) else $error("single wire master");
    sw_slave_a: assert property (s && opt_r[0] |-> mosi_oe_n
        && miso_oe_n == !(opt_r[3] && shift_drive)) else $error("sw slave");
    sep_master_a: assert property (m && !opt_r[0] |-> !mosi_oe_n
        && miso_oe_n && mosi_out == shift_out) else $error("sep master");
    sep_slave_a: assert property (s && !opt_r[0] |-> mosi_oe_n
        && miso_oe_n == !shift_drive) else $error("sep slave");
    wait_run_a: assert property (serial_clk_run
        == (spi_enable && !(cpu_wait && opt_r[1]))) else $error("wait gate");
    clk_stop_a: assert property (!run |=> !bit_clk)
        else $error("bit clock not stopped");
    rate_half_a: assert property (tog && ok_r |-> cnt_r == half)
        else $error("bit clock half period");
    // Pin data reaches the shifter through exactly two flops
    sep_data_in_a: assert property (m && !opt_r[0]
        |-> shift_in == $past(miso_in, 2)) else $error("master data in");
    sw_data_in_a: assert property (s && opt_r[0]
        |-> shift_in == $past(miso_in, 2)) else $error("slave data in");
    bit_tick_a: assert property (bit_tick
        == ($fell(bit_clk) && $past(run))) else $error("bit tick");
    c_tog: cover property (tog && ok_r);
    c_sso: cover property (sso && ss_assert);
    c_sws: cover property (s && opt_r[0] && opt_r[3] && shift_drive);
endmodule
bind spbr_pin_ctrl spbr_pin_ctrl_chk chk (.*);

// file: tb/spbr_far_end.sv
module spbr_far_end (
    input wire logic sys_clk,
    input wire logic ss_low,
    input wire logic mosi_out,
    input wire logic mosi_oe_n,
    input wire logic miso_out,
    input wire logic miso_oe_n,
    input wire logic ss_out,
    input wire logic ss_oe_n,
    output logic mosi_w,
    output logic miso_w,
    output logic ss_w
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pat_r = 1'b0;
    // Undriven data lines toggle so a stale level never looks valid
    always @(posedge sys_clk) pat_r <= ~pat_r;
    assign mosi_w = mosi_oe_n ? pat_r : mosi_out;
    assign miso_w = miso_oe_n ? ~pat_r : miso_out;
    // Select line is pulled up; the far master pulls it low on command
    assign ss_w = ss_oe_n ? ~ss_low : ss_out;
endmodule

// file: tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import spbr_pkg::*;
    logic sys_clk, sys_rst, reg_wr, reg_rd, master_select, spi_enable;
    logic slave_select_output_enable, cpu_wait, shift_active, shift_out;
    logic shift_drive, ss_assert, shift_in, slave_select_in, mode_fault_in;
    logic serial_clk_run, bit_tick, bit_clk, mosi_in, mosi_out, mosi_oe_n;
    logic mosi_spi_owned, miso_in, miso_out, miso_oe_n, miso_spi_owned;
    logic ss_pin_in, ss_out, ss_oe_n, ss_spi_owned, ss_low;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [31:0] seed = 32'h5d7f;
    int errors = 0;
    int check_count = 0;
    spbr_pin_ctrl dut (.*);
    spbr_far_end far (.sys_clk, .ss_low, .mosi_out, .mosi_oe_n, .miso_out,
        .miso_oe_n, .ss_out, .ss_oe_n, .mosi_w(mosi_in), .miso_w(miso_in),
        .ss_w(ss_pin_in));
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Pin steering expected of an enabled port under option byte o
    function automatic logic [7:0] pins(input logic [7:0] o);
        logic m, sw, mf, se, s;
        m = master_select;
        sw = o[0];
        mf = o[4] & m;
        se = slave_select_output_enable;
        s = ~ss_low;
        return {~m | (sw & ~o[3]), m | ~(shift_drive & (~sw | o[3])),
            ~(m & sw), ~m | mf, ~(mf & se), ~(mf & ~se) | s, m | s,
            ~(cpu_wait & o[1])};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(16'(reg_rdata), 16'(e));
    endtask
    // Cycles until bit_clk next changes; bounded so a dead clock shows
    task automatic meas(output int c);
        logic b;
        b = bit_clk;
        c = 0;
        while (bit_clk === b && c < 2100)
        begin
            @(posedge sys_clk);
            #1 c++;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #300000;
        errors++;
        $display("ERROR %0t watchdog expired", $time);
        wrap_up();
    end
    initial
    begin
        int c;
        logic [31:0] r;
        logic [7:0] w, got;
        sys_rst = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata, master_select, spi_enable,
            slave_select_output_enable, cpu_wait, shift_active, shift_out,
            shift_drive, ss_assert, ss_low} = '0;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(SPBR_OFF_OPTION, 8'h00);
        rd(SPBR_OFF_RATE, 8'h00);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h00);
        rd(SPBR_OFF_OPTION, 8'h00);
        spi_enable <= 1'b1;
        for (int i = 0; i < 128; i++)
        begin
            r = rnd();
            w = {r[7:5], i[0], i[1], r[2:1], i[2]};
            wr(SPBR_OFF_OPTION, w);
            rd(SPBR_OFF_OPTION, w & 8'h1b);
            @(posedge sys_clk);
            {master_select, slave_select_output_enable, cpu_wait, ss_low,
                shift_drive, shift_out, ss_assert, shift_active}
                <= {i[6:3], r[11:8]};
            repeat (4) @(posedge sys_clk);
            #1 got = {mosi_oe_n, miso_oe_n, miso_spi_owned, ss_spi_owned,
                ss_oe_n, mode_fault_in, slave_select_in, serial_clk_run};
            chk(16'(got), 16'(pins(w)));
        end
        @(posedge sys_clk);
        {master_select, cpu_wait} <= 2'b10;
        wr(SPBR_OFF_OPTION, 8'h00);
        for (int p = 0; p < 8; p++)
            for (int d = 0; d < 8; d++)
            begin
                r = rnd();
                w = {r[7], p[2:0], r[3], d[2:0]};
                wr(SPBR_OFF_RATE, w);
                rd(SPBR_OFF_RATE, w & 8'h77);
                repeat (3) meas(c);
                chk(16'(c), 16'((p + 1) << d));
            end
        wr(SPBR_OFF_RATE, 8'h21);
        wr(SPBR_OFF_OPTION, 8'h02);
        @(posedge sys_clk);
        cpu_wait <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 chk(16'({serial_clk_run, bit_clk}), 16'h0);
        wr(SPBR_OFF_OPTION, 8'h00);
        repeat (3) meas(c);
        chk(16'(c), 16'h6);
        wrap_up();
    end
endmodule
